/* File: logic/enc_defs.svh */
`ifndef ENC_DEFS_SVH
`define ENC_DEFS_SVH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ENC_ADR_CTRL   8'h00
`define ENC_ADR_FILT   8'h04
`define ENC_ADR_POS    8'h08
`define ENC_ADR_MAX    8'h0C
// ----------------------------------------
// control register fields
// ----------------------------------------
`define ENC_C_COUNT_ERROR_FLAG   15
`define ENC_C_IDLE     13
`define ENC_C_INDEX    12
`define ENC_C_DIR      11
`define ENC_C_MODE_H   10
`define ENC_C_MODE_L   8
`define ENC_C_SWAP     7
`define ENC_C_DIROE    6
`define ENC_C_GATE     5
`define ENC_C_PS_H     4
`define ENC_C_PS_L     3
`define ENC_C_IDXRES   2
`define ENC_C_CLKSRC   1
`define ENC_C_DIRSRC   0
// ----------------------------------------
// filter control register fields
// ----------------------------------------
`define ENC_F_IMV_H    10
`define ENC_F_IMV_L    9
`define ENC_F_COUNT_ERROR_IRQ_DISABLE     8
`define ENC_F_FEN      7
`define ENC_F_FCK_H    6
`define ENC_F_FCK_L    4
// ----------------------------------------
// reset values and terminal counts
// ----------------------------------------
`define ENC_MAX_RST    16'hFFFF
`define ENC_POS_RST    16'h0000
`define ENC_FLT_STABLE 3
`define ENC_TERM_1     8'h00
`define ENC_TERM_2     8'h01
`define ENC_TERM_4     8'h03
`define ENC_TERM_8     8'h07
`define ENC_TERM_16    8'h0F
`define ENC_TERM_32    8'h1F
`define ENC_TERM_64    8'h3F
`define ENC_TERM_128   8'h7F
`define ENC_TERM_256   8'hFF
`endif

/* File: logic/enc_pkg.sv */
package enc_pkg;
  // operating mode as held in the control register
  typedef enum logic [2:0] {
    ENC_OFF    = 3'h0,
    ENC_TIMER  = 3'h1,
    ENC_UNUSED = 3'h2,
    ENC_UNUSD3 = 3'h3,
    ENC_X2_IDX = 3'h4,
    ENC_X2_MAX = 3'h5,
    ENC_X4_IDX = 3'h6,
    ENC_X4_MAX = 3'h7
  } enc_mode_e;
endpackage

/* File: logic/enc_core.sv */
`timescale 1ns/1ns
`include "enc_defs.svh"

// Behaviour
// - modes 111/110 x4, max or index reset
// - modes 101/100 x2, max or index reset
// - 001 timer/counter, 000 everything off
// - 011 and 010 keep module disabled
// - count error flag in index modes
// - error interrupt unless disable bit set
// - idle stop halts counting in idle
// - status bit shows index pin level
// - direction bit, writable only in timer
// - swap bit exchanges phase A and B
// - direction driven onto pin when enabled
// - gate enable counts only while gated
// - timer prescale 1, 8, 64, 256
// - prescaler used only in timer mode
// - index reset enable in index modes
// - timer clock internal or phase A rise
// - timer direction from phase B or bit
// - x4 index needs both phase levels
// - x2 index checks one selected phase
// - filter enable routes inputs through filters
// - filter clock divide 1 through 256
// - 16-bit up/down position counter
module enc_core #(
  parameter int CNT_W = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        wbCyc,
  input  wire logic        wbStb,
  input  wire logic        wbWe,
  input  wire logic [7:0]  wbAdr,
  input  wire logic [3:0]  wbSel,
  input  wire logic [31:0] wbDatIn,
  output logic             wbAck,
  output logic      [31:0] wbDatOut,
  input  wire logic        phaseAPin,
  input  wire logic        phaseBPin,
  input  wire logic        indexPin,
  input  wire logic        idleMode,
  output logic             dirOut,
  output logic             dirOe,
  output logic             countErrIrq
);

  // ----------------------------------------
  // helper functions
  // ----------------------------------------
  // next counter value; wrap selects rollover at max and zero
  function automatic logic [CNT_W-1:0] nextCount(
    input logic [CNT_W-1:0] cnt,
    input logic [CNT_W-1:0] lim,
    input logic             up,
    input logic             wrap
  );
    if (up)
      nextCount = (wrap && cnt == lim) ? '0 : cnt + 1'b1;
    else
      nextCount = (wrap && cnt == '0) ? lim : cnt - 1'b1;
  endfunction

  // byte-lane merge for 16-bit registers
  function automatic logic [15:0] laneMerge(
    input logic [15:0] old,
    input logic [31:0] dat,
    input logic [3:0]  sel
  );
    laneMerge = {sel[1] ? dat[15:8] : old[15:8],
                 sel[0] ? dat[7:0]  : old[7:0]};
  endfunction

  // filter clock divide code to terminal count
  function automatic logic [7:0] filtTerm(input logic [2:0] code);
    case (code)
      3'h0:    filtTerm = `ENC_TERM_1;
      3'h1:    filtTerm = `ENC_TERM_2;
      3'h2:    filtTerm = `ENC_TERM_4;
      3'h3:    filtTerm = `ENC_TERM_16;
      3'h4:    filtTerm = `ENC_TERM_32;
      3'h5:    filtTerm = `ENC_TERM_64;
      3'h6:    filtTerm = `ENC_TERM_128;
      default: filtTerm = `ENC_TERM_256;
    endcase
  endfunction

  // timer prescale code to terminal count
  function automatic logic [7:0] preTerm(input logic [1:0] code);
    case (code)
      2'h0:    preTerm = `ENC_TERM_1;
      2'h1:    preTerm = `ENC_TERM_8;
      2'h2:    preTerm = `ENC_TERM_64;
      default: preTerm = `ENC_TERM_256;
    endcase
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  enc_pkg::enc_mode_e mode_q;
  logic             count_error_flag_q;
  logic             idleStop_q;
  logic             dirStat_q;
  logic             swap_q;
  logic             dirOutEn_q;
  logic             gateEn_q;
  logic [1:0]       prescale_q;
  logic             idxResEn_q;
  logic             clkSrc_q;
  logic             dirSrc_q;
  logic [1:0]       imv_q;
  logic             count_error_irq_disable_q;
  logic             filtEn_q;
  logic [2:0]       filtDiv_q;
  logic [CNT_W-1:0] pos_q;
  logic [CNT_W-1:0] max_q;
  logic [2:0]       sync1_q;
  logic [2:0]       sync2_q;
  logic [2:0]       hist_q [`ENC_FLT_STABLE-1];
  logic [2:0]       filt_q;
  logic [7:0]       filtCnt_q;
  logic [7:0]       preCnt_q;
  logic             prevA_q;
  logic             prevB_q;
  logic             prevI_q;
  logic             wbAck_q;
  logic [31:0]      wbDat_q;
  logic             dirOut_q;
  logic             dirOe_q;
  logic             irq_q;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic req;
  logic wrEn;
  logic wrCtrl;
  logic wrFilt;
  logic wrPos;
  logic wrMax;
  logic [15:0] ctrlRd;
  logic [15:0] filtRd;
  logic [15:0] ctrlNew;
  logic [15:0] filtNew;

  // writes land on the edge where the master sees ack
  assign req    = wbCyc & wbStb;
  assign wrEn   = req & wbWe & wbAck_q;
  assign wrCtrl = wrEn & (wbAdr == `ENC_ADR_CTRL);
  assign wrFilt = wrEn & (wbAdr == `ENC_ADR_FILT);
  assign wrPos  = wrEn & (wbAdr == `ENC_ADR_POS);
  assign wrMax  = wrEn & (wbAdr == `ENC_ADR_MAX);
  assign ctrlNew = laneMerge(ctrlRd, wbDatIn, wbSel);
  assign filtNew = laneMerge(filtRd, wbDatIn, wbSel);

  // ----------------------------------------
  // decoded inputs and mode terms
  // ----------------------------------------
  logic [2:0] pins;
  logic pA;
  logic pB;
  logic pI;
  logic quadMode;
  logic x4Mode;
  logic idxMode;
  logic timerMode;
  logic halt;
  logic aChg;
  logic bChg;
  logic qUp;
  logic qStep;
  logic qErr;
  logic idxHit;
  logic idxClr;
  logic srcEdge;
  logic gateOk;
  logic preTick;
  logic tStep;
  logic tUp;
  logic filtTick;

  // filters bypassed unless enabled; synchroniser stage 2 only
  assign pins = filtEn_q ? filt_q : sync2_q;
  assign pA   = swap_q ? pins[1] : pins[0];
  assign pB   = swap_q ? pins[0] : pins[1];
  assign pI   = pins[2];

  // unused codes fall out of every mode term except x4Mode, which quadMode gates
  assign quadMode  = mode_q[2];
  assign x4Mode    = mode_q[1];
  assign idxMode   = quadMode & ~mode_q[0];
  assign timerMode = (mode_q == enc_pkg::ENC_TIMER);
  assign halt      = idleStop_q & idleMode;

  // quadrature edge decode; direction from new A and old B
  assign aChg  = pA ^ prevA_q;
  assign bChg  = pB ^ prevB_q;
  assign qUp   = pA ^ prevB_q;
  assign qStep = quadMode & ~halt & (x4Mode ? (aChg ^ bChg) : (aChg & ~bChg));
  assign qErr  = quadMode & ~halt & aChg & bChg;

  // index reset qualification
  assign idxHit = x4Mode ? (pB == imv_q[1] && pA == imv_q[0])
                         : ((imv_q[1] ? pB : pA) == imv_q[0]);
  assign idxClr = idxMode & ~halt & idxResEn_q & pI & ~prevI_q & idxHit;

  // timer clock, gate and prescaler
  assign srcEdge = clkSrc_q ? (pA & ~prevA_q) : 1'b1;
  assign gateOk  = ~gateEn_q | pA;
  assign preTick = timerMode & ~halt & srcEdge & gateOk;
  assign tStep   = preTick & (preCnt_q == preTerm(prescale_q));
  assign tUp     = dirSrc_q ? pB : dirStat_q;

  assign filtTick = (filtCnt_q == filtTerm(filtDiv_q));

  // ----------------------------------------
  // input synchronisers and noise filters
  // ----------------------------------------
  // two flops per pin before anything reads the level
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {indexPin, phaseBPin, phaseAPin};
      sync2_q <= sync1_q;
    end
  end

  // divided sample clock shared by all three filters
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      filtCnt_q <= 8'h00;
    else if (filtTick)
      filtCnt_q <= 8'h00;
    else
      filtCnt_q <= filtCnt_q + 8'h01;
  end

  // a level is taken only after three equal samples in a row:
  // the current sample and the two held in the history
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < `ENC_FLT_STABLE-1; i++)
        hist_q[i] <= 3'h0;
      filt_q <= 3'h0;
    end
    else if (filtTick)
    begin
      hist_q[0] <= sync2_q;
      for (int i = 1; i < `ENC_FLT_STABLE-1; i++)
        hist_q[i] <= hist_q[i-1];
      for (int c = 0; c < 3; c++)
        if (hist_q[0][c] == sync2_q[c] && hist_q[1][c] == sync2_q[c])
          filt_q[c] <= sync2_q[c];
    end
  end

  // previous decoded levels for edge detection
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prevA_q <= 1'b0;
      prevB_q <= 1'b0;
      prevI_q <= 1'b0;
    end
    else
    begin
      prevA_q <= pA;
      prevB_q <= pB;
      prevI_q <= pI;
    end
  end

  // ----------------------------------------
  // timer prescaler
  // ----------------------------------------
  // cleared outside timer mode so a new start begins at zero
  always_ff @(posedge clk_sys)
  begin
    if (rst || !timerMode)
      preCnt_q <= 8'h00;
    else if (tStep)
      preCnt_q <= 8'h00;
    else if (preTick)
      preCnt_q <= preCnt_q + 8'h01;
  end

  // ----------------------------------------
  // position counter and limit
  // ----------------------------------------
  // software write wins over a count in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      pos_q <= `ENC_POS_RST;
    else if (wrPos)
      pos_q <= laneMerge(pos_q, wbDatIn, wbSel);
    else if (idxClr)
      pos_q <= '0;
    else if (qStep)
      pos_q <= nextCount(pos_q, max_q, qUp, mode_q[0]);
    else if (tStep)
      pos_q <= nextCount(pos_q, max_q, tUp, 1'b1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      max_q <= `ENC_MAX_RST;
    else if (wrMax)
      max_q <= laneMerge(max_q, wbDatIn, wbSel);
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_q     <= enc_pkg::ENC_OFF;
      idleStop_q <= 1'b0;
      swap_q     <= 1'b0;
      dirOutEn_q <= 1'b0;
      gateEn_q   <= 1'b0;
      prescale_q <= 2'h0;
      idxResEn_q <= 1'b0;
      clkSrc_q   <= 1'b0;
      dirSrc_q   <= 1'b0;
    end
    else if (wrCtrl)
    begin
      mode_q     <= enc_pkg::enc_mode_e'(ctrlNew[`ENC_C_MODE_H:`ENC_C_MODE_L]);
      idleStop_q <= ctrlNew[`ENC_C_IDLE];
      swap_q     <= ctrlNew[`ENC_C_SWAP];
      dirOutEn_q <= ctrlNew[`ENC_C_DIROE];
      gateEn_q   <= ctrlNew[`ENC_C_GATE];
      prescale_q <= ctrlNew[`ENC_C_PS_H:`ENC_C_PS_L];
      idxResEn_q <= ctrlNew[`ENC_C_IDXRES];
      clkSrc_q   <= ctrlNew[`ENC_C_CLKSRC];
      dirSrc_q   <= ctrlNew[`ENC_C_DIRSRC];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      imv_q     <= 2'h0;
      count_error_irq_disable_q    <= 1'b0;
      filtEn_q  <= 1'b0;
      filtDiv_q <= 3'h0;
    end
    else if (wrFilt)
    begin
      imv_q     <= filtNew[`ENC_F_IMV_H:`ENC_F_IMV_L];
      count_error_irq_disable_q    <= filtNew[`ENC_F_COUNT_ERROR_IRQ_DISABLE];
      filtEn_q  <= filtNew[`ENC_F_FEN];
      filtDiv_q <= filtNew[`ENC_F_FCK_H:`ENC_F_FCK_L];
    end
  end

  // hardware owns direction in quadrature modes, software in timer unless dirSrc_q selects phase B
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      dirStat_q <= 1'b0;
    else if (qStep)
      dirStat_q <= qUp;
    else if (timerMode && dirSrc_q)
      dirStat_q <= pB;
    else if (wrCtrl && timerMode)
      dirStat_q <= ctrlNew[`ENC_C_DIR];
  end

  // set wins over a software clear in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      count_error_flag_q <= 1'b0;
    else if (qErr && idxMode)
      count_error_flag_q <= 1'b1;
    else if (wrCtrl)
      count_error_flag_q <= count_error_flag_q & ctrlNew[`ENC_C_COUNT_ERROR_FLAG];
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dirOut_q <= 1'b0;
      dirOe_q  <= 1'b0;
      irq_q    <= 1'b0;
    end
    else
    begin
      dirOut_q <= dirStat_q;
      dirOe_q  <= dirOutEn_q;
      irq_q    <= qErr & idxMode & ~count_error_irq_disable_q;
    end
  end

  assign dirOut      = dirOut_q;
  assign dirOe       = dirOe_q;
  assign countErrIrq = irq_q;

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  assign ctrlRd = {count_error_flag_q, 1'b0, idleStop_q, pI, dirStat_q,
                   mode_q, swap_q, dirOutEn_q, gateEn_q, prescale_q,
                   idxResEn_q, clkSrc_q, dirSrc_q};
  assign filtRd = {5'h00, imv_q, count_error_irq_disable_q, filtEn_q, filtDiv_q, 4'h0};

  // one wait state; ack drops the cycle after it was given
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wbAck_q <= 1'b0;
      wbDat_q <= 32'h0000_0000;
    end
    else
    begin
      wbAck_q <= req & ~wbAck_q;
      if (req && !wbAck_q)
        case (wbAdr)
          `ENC_ADR_CTRL: wbDat_q <= {16'h0000, ctrlRd};
          `ENC_ADR_FILT: wbDat_q <= {16'h0000, filtRd};
          `ENC_ADR_POS:  wbDat_q <= {16'h0000, pos_q};
          `ENC_ADR_MAX:  wbDat_q <= {16'h0000, max_q};
          default:       wbDat_q <= 32'h0000_0000; // unmapped reads zero
        endcase
    end
  end

  assign wbAck    = wbAck_q;
  assign wbDatOut = wbDat_q;

endmodule // enc_core

/* File: verification/enc_checker.sv */
`timescale 1ns/1ns
// ---
// port checker
// ---
module enc_checker (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbWe,
  input wire logic [7:0]  wbAdr,
  input wire logic [3:0]  wbSel,
  input wire logic [31:0] wbDatIn,
  input wire logic        wbAck,
  input wire logic [31:0] wbDatOut,
  input wire logic        phaseAPin,
  input wire logic        phaseBPin,
  input wire logic        indexPin,
  input wire logic        idleMode,
  input wire logic        dirOut,
  input wire logic        dirOe,
  input wire logic        countErrIrq
);
  logic oeQ;
  logic ceidQ;
  // shadow of two config bits, taken at the acked write
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      oeQ   <= 1'b0;
      ceidQ <= 1'b0;
    end
    else if (wbAck && wbWe)
    begin
      if (wbAdr == 8'h00 && wbSel[0])
        oeQ <= wbDatIn[6];
      if (wbAdr == 8'h04 && wbSel[1])
        ceidQ <= wbDatIn[8];
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence seqReq;
    wbCyc && wbStb && !wbAck;
  endsequence
  sequence seqAck;
    wbAck ##1 !wbAck;
  endsequence
  a_ack_timing: assert property (seqReq |=> seqAck)
    else $error("ack timing wrong");
  a_ack_cause: assert property (wbAck |-> $past(wbCyc && wbStb))
    else $error("ack without request");
  a_read_upper: assert property (wbAck && !wbWe |-> wbDatOut[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_read_unmapped: assert property (wbAck && !wbWe && wbAdr > 8'h0C |-> wbDatOut == 32'h0)
    else $error("unmapped read not zero");
  a_filter_gaps: assert property (wbAck && !wbWe && wbAdr == 8'h04
    |-> wbDatOut[15:11] == 5'h00 && wbDatOut[3:0] == 4'h0)
    else $error("reserved filter bits set");
  a_oe_follow: assert property (oeQ == $past(oeQ) |-> dirOe == oeQ)
    else $error("direction enable mismatch");
  a_irq_masked: assert property (ceidQ && $past(ceidQ) |-> !countErrIrq)
    else $error("masked error irq raised");
  // reset is the antecedent here, so the default disable must not apply
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> !wbAck && !countErrIrq && !dirOe)
    else $error("output active after reset");
endmodule // enc_checker

bind enc_core enc_checker i_enc_checker (
  .clk_sys(clk_sys), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
  .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbAck(wbAck), .wbDatOut(wbDatOut),
  .phaseAPin(phaseAPin), .phaseBPin(phaseBPin), .indexPin(indexPin),
  .idleMode(idleMode), .dirOut(dirOut), .dirOe(dirOe), .countErrIrq(countErrIrq)
);

/* File: verification/enc_encoder_model.sv */
`timescale 1ns/1ns
// ---
// incremental encoder with index
// ---
module enc_encoder_model (
  input  wire logic clk_sys,
  output logic      phaseA,
  output logic      phaseB,
  output logic      index
);
  logic [1:0] angle_q = 2'h0;
  // gray order 00 10 11 01, so a legal step moves one line only
  assign phaseA = angle_q[1] ^ angle_q[0];
  assign phaseB = angle_q[1];
  initial index = 1'b0;
  // one quarter cycle forward (A leads B) or back
  task automatic step(input logic up);
    @(posedge clk_sys);
    angle_q <= up ? angle_q + 2'h1 : angle_q - 2'h1;
  endtask
  // both lines at once: a real encoder only does this when it is faulty
  task automatic jump;
    @(posedge clk_sys);
    angle_q <= angle_q + 2'h2;
  endtask
  task automatic setIndex(input logic v);
    @(posedge clk_sys);
    index <= v;
  endtask
endmodule // enc_encoder_model

/* File: verification/enc_core_tb.sv */
`timescale 1ns/1ns
module enc_core_tb;
  logic        clk_sys  = 1'b0;
  logic        rst      = 1'b1;
  logic        wbCyc    = 1'b0;
  logic        wbStb    = 1'b0;
  logic        wbWe     = 1'b0;
  logic [7:0]  wbAdr    = 8'h00;
  logic [3:0]  wbSel    = 4'h0;
  logic [31:0] wbDatIn  = 32'h0;
  logic        idleMode = 1'b0;
  logic        wbAck;
  logic [31:0] wbDatOut;
  logic        phaseAPin;
  logic        phaseBPin;
  logic        indexPin;
  logic        dirOut;
  logic        dirOe;
  logic        countErrIrq;
  logic [15:0] rv;
  int          bad_count   = 0;
  int          checks_done = 0;
  int          ticks       = 0;
  int          n;

  always #5 clk_sys = ~clk_sys;

  enc_core i_enc_core (
    .clk_sys(clk_sys), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbAck(wbAck), .wbDatOut(wbDatOut),
    .phaseAPin(phaseAPin), .phaseBPin(phaseBPin), .indexPin(indexPin),
    .idleMode(idleMode), .dirOut(dirOut), .dirOe(dirOe), .countErrIrq(countErrIrq)
  );
  enc_encoder_model i_enc_encoder_model (
    .clk_sys(clk_sys), .phaseA(phaseAPin), .phaseB(phaseBPin), .index(indexPin)
  );

  // ---
  // tasks
  // ---
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // request held until the acking edge, data taken there
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [15:0] dat,
                      input logic [3:0] sel);
    @(posedge clk_sys);
    wbCyc   <= 1'b1;
    wbStb   <= 1'b1;
    wbWe    <= we;
    wbAdr   <= adr;
    wbSel   <= sel;
    wbDatIn <= {16'h0000, dat};
    // only the bench timeout ends a wait that never sees ack
    do
    begin
      @(posedge clk_sys);
    end
    while (wbAck !== 1'b1);
    rv = wbDatOut[15:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [15:0] dat);
    xfer(1'b1, adr, dat, 4'h3);
  endtask

  task automatic rd(input logic [7:0] adr);
    xfer(1'b0, adr, 16'h0000, 4'h3);
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus latency adds a few counts, so a window rather than a value
  task automatic cmpIn(input logic [15:0] got, input int lo, input int hi);
    checks_done++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, lo);
    end
  endtask

  task automatic stp(input logic up, input int w);
    i_enc_encoder_model.step(up);
    repeat (w) @(posedge clk_sys);
  endtask

  task automatic cntIrq;
    n = 0;
    repeat (12)
    begin
      @(posedge clk_sys);
      if (countErrIrq === 1'b1)
        n++;
    end
  endtask

  task automatic idxTry(input logic [15:0] filt, input logic [15:0] ctrl,
                        input logic [15:0] exp);
    wr(8'h04, filt);
    wr(8'h00, ctrl);
    wr(8'h08, 16'h1234);
    i_enc_encoder_model.setIndex(1'b1);
    repeat (6) @(posedge clk_sys);
    rd(8'h00);
    cmp(rv & 16'h1000, 16'h1000);
    i_enc_encoder_model.setIndex(1'b0);
    repeat (6) @(posedge clk_sys);
    rd(8'h08);
    cmp(rv, exp);
  endtask

  // ---
  // scenarios
  // ---
  task automatic testReset;
    rd(8'h00);
    cmp(rv, 16'h0000);
    rd(8'h04);
    cmp(rv, 16'h0000);
    rd(8'h08);
    cmp(rv, 16'h0000);
    rd(8'h0C);
    cmp(rv, 16'hFFFF);
    xfer(1'b1, 8'h0C, 16'h1234, 4'h1);
    rd(8'h0C);
    cmp(rv, 16'hFF34);
    wr(8'h0C, 16'hFFFF);
    wr(8'h10, 16'hFFFF);
    rd(8'h10);
    cmp(rv, 16'h0000);
    $display("test reset done");
  endtask

  task automatic testX2;
    wr(8'h00, 16'h0500);
    wr(8'h08, 16'h0000);
    repeat (4) stp(1'b1, 6);
    rd(8'h08);
    cmp(rv, 16'h0002);
    repeat (4) stp(1'b0, 6);
    rd(8'h08);
    cmp(rv, 16'h0000);
    wr(8'h00, 16'h0680);
    stp(1'b1, 6);
    rd(8'h08);
    cmp(rv, 16'hFFFF);
    stp(1'b0, 6);
    $display("test x2 done");
  endtask

  task automatic testX4;
    int i;
    wr(8'h0C, 16'h0003);
    wr(8'h00, 16'h0758);
    wr(8'h08, 16'h0000);
    for (i = 1; i <= 5; i++)
    begin
      stp(1'b1, 6);
      rd(8'h08);
      cmp(rv, 16'(i % 4));
    end
    cmp({15'h0000, dirOut}, 16'h0001);
    cmp({15'h0000, dirOe}, 16'h0001);
    rd(8'h00);
    cmp(rv & 16'h0800, 16'h0800);
    stp(1'b0, 6);
    stp(1'b0, 6);
    rd(8'h08);
    cmp(rv, 16'h0003);
    cmp({15'h0000, dirOut}, 16'h0000);
    wr(8'h00, 16'h0F40);
    rd(8'h00);
    cmp(rv & 16'h0800, 16'h0000);
    wr(8'h0C, 16'hFFFF);
    $display("test x4 done");
  endtask

  task automatic testOff;
    int m;
    for (m = 0; m < 4; m++)
    begin
      if (m != 1)
      begin
        wr(8'h00, 16'(m << 8));
        wr(8'h08, 16'h0000);
        repeat (4) stp(1'b1, 6);
        rd(8'h08);
        cmp(rv, 16'h0000);
      end
    end
    $display("test off done");
  endtask

  task automatic testTimer;
    int k;
    int sh;
    wr(8'h00, 16'h0800);
    rd(8'h00);
    cmp(rv & 16'h0800, 16'h0000);
    for (k = 0; k < 4; k++)
    begin
      sh = (k == 3) ? 8 : 3 * k;
      wr(8'h08, 16'h0000);
      wr(8'h00, 16'h0100 | 16'(k << 3));
      wr(8'h00, 16'h0900 | 16'(k << 3));
      repeat (512) @(posedge clk_sys);
      rd(8'h00);
      cmp(rv & 16'h0800, 16'h0800);
      wr(8'h00, 16'h0000);
      rd(8'h08);
      cmpIn(rv, (512 >> sh) - 1, (512 >> sh) + 1 + (10 >> sh));
    end
    wr(8'h08, 16'h0000);
    idleMode <= 1'b1;
    wr(8'h00, 16'h2100);
    wr(8'h00, 16'h2900);
    repeat (100) @(posedge clk_sys);
    wr(8'h00, 16'h0000);
    idleMode <= 1'b0;
    rd(8'h08);
    cmp(rv, 16'h0000);
    wr(8'h00, 16'h0102);
    wr(8'h00, 16'h0902);
    repeat (4) stp(1'b1, 6);
    wr(8'h00, 16'h0000);
    rd(8'h08);
    cmp(rv, 16'h0001);
    // phase A rests low and B high: gate shuts, direction follows B
    wr(8'h08, 16'h0000);
    wr(8'h00, 16'h0121);
    repeat (50) @(posedge clk_sys);
    rd(8'h00);
    cmp(rv & 16'h0800, 16'h0800);
    wr(8'h00, 16'h0000);
    rd(8'h08);
    cmp(rv, 16'h0000);
    $display("test timer done");
  endtask

  task automatic testIndex;
    stp(1'b0, 6);
    idxTry(16'h0600, 16'h0604, 16'h0000);
    idxTry(16'h0200, 16'h0604, 16'h1234);
    idxTry(16'h0600, 16'h0600, 16'h1234);
    idxTry(16'h0600, 16'h0404, 16'h0000);
    idxTry(16'h0400, 16'h0404, 16'h1234);
    $display("test index done");
  endtask

  task automatic testError;
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h0600);
    wr(8'h08, 16'h1234);
    i_enc_encoder_model.jump();
    cntIrq();
    cmp(16'(n), 16'h0001);
    rd(8'h08);
    cmp(rv, 16'h1234);
    rd(8'h00);
    cmp(rv & 16'h8000, 16'h8000);
    wr(8'h00, 16'h0600);
    rd(8'h00);
    cmp(rv & 16'h8000, 16'h0000);
    wr(8'h04, 16'h0100);
    i_enc_encoder_model.jump();
    cntIrq();
    cmp(16'(n), 16'h0000);
    rd(8'h00);
    cmp(rv & 16'h8000, 16'h8000);
    $display("test error done");
  endtask

  // a one-cycle glitch must die in the filter, a slow divide must delay
  task automatic testFilt;
    wr(8'h04, 16'h0080);
    wr(8'h00, 16'h0500);
    wr(8'h08, 16'h0000);
    repeat (4) stp(1'b1, 20);
    rd(8'h08);
    cmp(rv, 16'h0002);
    stp(1'b1, 0);
    stp(1'b0, 20);
    rd(8'h08);
    cmp(rv, 16'h0002);
    wr(8'h04, 16'h00F0);
    stp(1'b1, 300);
    rd(8'h08);
    cmp(rv, 16'h0002);
    repeat (600) @(posedge clk_sys);
    rd(8'h08);
    cmp(rv, 16'h0003);
    $display("test filter done");
  endtask

  // ceiling well above the few thousand cycles the tests need
  always @(posedge clk_sys)
  begin
    ticks++;
    if (ticks == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end

  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    testReset();
    testX2();
    testX4();
    testOff();
    testTimer();
    testIndex();
    testError();
    testFilt();
    end_sim();
  end
endmodule // enc_core_tb
